// ===== core/flash_regs_pkg.sv
// Purpose: Constants for the flash protection and command register front end
// Assumes: Byte-wide register port, one register per offset
// Notes: Offsets other than the reserved test register are local choices
package flash_regs_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_STATUS = 5'h06;
  localparam logic [4:0] OFF_IRQ_MASK = 5'h07;
  localparam logic [4:0] OFF_DF_PROT = 5'h09;
  localparam logic [4:0] OFF_CMD_INDEX = 5'h02;
  localparam logic [4:0] OFF_COB_HI = 5'h0A;
  localparam logic [4:0] OFF_COB_LO = 5'h0B;
  localparam logic [4:0] OFF_RSV_TEST = 5'h0C;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h0D;
  // Status bit positions
  localparam int BIT_COMPLETE = 7;
  localparam int BIT_ACCESS_ERROR_FLAG = 5;
  localparam int BIT_PVIOL = 4;
  // Protection register layout
  localparam int BIT_DISABLE = 7;
  localparam int SIZE_W = 5;
  localparam logic [7:0] PROT_FULL = 8'h1F;
  localparam logic [22:0] DF_BASE = 23'h10_0000;
  localparam int SECTOR_SHIFT = 8;
  // Command object
  localparam int COB_WORDS = 6;
  localparam logic [2:0] IDX_LAST = 3'h5;
  localparam logic [2:0] IDX_ADDR_HI = 3'h0;
  localparam logic [2:0] IDX_ADDR_LO = 3'h1;
  localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
  localparam logic [7:0] CMD_PROGRAM = 8'h11;
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h12;
  localparam logic [7:0] CMD_READ_PROT = 8'h01;
  // Interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_VIOL = 1;
  localparam int IRQ_W = 2;
  localparam int CMD_CYCLES = 8;
endpackage : flash_regs_pkg

// ===== core/flash_protect_command_regs.sv
// Purpose: Data-flash protection register and command object front end
// Assumes: Synchronous inputs; engine reports completion with results
// Notes: Engine modelled as a fixed busy time with a protection check
//
// Functional notes
// - Protection writes may only strengthen
// - Disable bit set leaves whole array open
// - Load protection byte from configuration at reset
// - Double fault at load protects everything
// - Protected program or erase sets violation
// - Block erase rejected if anything protected
// - Bit seven is the protection disable
// - Size field covers (n+1)*256 bytes from base
// - Six sixteen-bit words, indexed, byte access
// - Writing one to complete flag launches
// - Parameters locked while command runs
// - Results written back, readable when complete
// - Indices six, seven ignore writes, read zero
// - Word layout: command and address high, address low, four data
// - Reserved test register reads zero
// - Command object writes ignored while busy
`timescale 1ns/1ps
module flash_protect_command_regs #(
  parameter int CMD_CYCLES = flash_regs_pkg::CMD_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] cfg_prot_byte_in,
  input wire logic cfg_double_fault_in,
  input wire logic cfg_load_in,
  output logic [7:0] rdata_out,
  output logic irq_out,
  output logic busy_out,
  output logic [7:0] prot_out
);
  // ****************************************
  // State
  // ****************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } run_e;
  run_e state_q;
  run_e state_d;
  logic [7:0] prot_q;
  logic [15:0] cob_q [flash_regs_pkg::COB_WORDS];
  logic [2:0] index_q;
  logic complete_q;
  logic access_error_flag_q;
  logic pviol_q;
  logic [flash_regs_pkg::IRQ_W-1:0] irq_stat_q;
  logic [flash_regs_pkg::IRQ_W-1:0] irq_mask_q;
  logic [7:0] count_q;
  logic [7:0] rdata_q;
  logic irq_q;
  // ****************************************
  // Decode
  // ****************************************
  wire wr_status = wr_in && addr_in == flash_regs_pkg::OFF_STATUS;
  wire wr_prot = wr_in && addr_in == flash_regs_pkg::OFF_DF_PROT;
  wire wr_index = wr_in && addr_in == flash_regs_pkg::OFF_CMD_INDEX;
  wire wr_mask = wr_in && addr_in == flash_regs_pkg::OFF_IRQ_MASK;
  wire wr_hi = wr_in && addr_in == flash_regs_pkg::OFF_COB_HI;
  wire wr_lo = wr_in && addr_in == flash_regs_pkg::OFF_COB_LO;
  wire rd_irq = rd_in && addr_in == flash_regs_pkg::OFF_IRQ_STAT;
  wire idx_ok = index_q <= flash_regs_pkg::IDX_LAST;
  wire cob_wr_ok = complete_q && idx_ok;
  wire launch = wr_status && wdata_in[flash_regs_pkg::BIT_COMPLETE] && complete_q
    && !access_error_flag_q && !pviol_q;
  wire clr_access_error_flag = wr_status && wdata_in[flash_regs_pkg::BIT_ACCESS_ERROR_FLAG];
  wire clr_pviol = wr_status && wdata_in[flash_regs_pkg::BIT_PVIOL];
  // Protection write acceptance: size may grow, disable only 1 to 0
  wire prot_dis = prot_q[flash_regs_pkg::BIT_DISABLE];
  wire new_dis = wdata_in[flash_regs_pkg::BIT_DISABLE];
  wire [4:0] cur_size = prot_q[4:0];
  wire [4:0] new_size = wdata_in[4:0];
  wire dis_ok = !new_dis || prot_dis;
  wire size_ok = prot_dis || new_dis || new_size >= cur_size;
  wire prot_accept = wr_prot && complete_q && dis_ok && size_ok;
  // ****************************************
  // Protection check of launched command
  // ****************************************
  wire [7:0] cmd_code = cob_q[flash_regs_pkg::IDX_ADDR_HI][15:8];
  wire [22:0] gaddr = {cob_q[flash_regs_pkg::IDX_ADDR_HI][6:0],
    cob_q[flash_regs_pkg::IDX_ADDR_LO]};
  wire [22:0] prot_end = flash_regs_pkg::DF_BASE
    + {10'h000, cur_size, 8'hFF};
  wire in_prot = !prot_dis && gaddr >= flash_regs_pkg::DF_BASE
    && gaddr <= prot_end;
  wire is_alter = cmd_code == flash_regs_pkg::CMD_PROGRAM
    || cmd_code == flash_regs_pkg::CMD_ERASE_SECTOR;
  wire blk_erase = cmd_code == flash_regs_pkg::CMD_ERASE_BLOCK;
  wire violate = (is_alter && in_prot) || (blk_erase && !prot_dis);
  wire finish = state_q == ST_RUN && count_q == 8'(CMD_CYCLES - 1);
  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (launch) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (finish) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end
  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= ST_IDLE;
      count_q <= 8'h00;
      complete_q <= 1'b1;
      index_q <= 3'h0;
      irq_mask_q <= '0;
    end else begin
      state_q <= state_d;
      count_q <= (state_q == ST_RUN && !finish) ? count_q + 8'h01 : 8'h00;
      if (launch) begin
        complete_q <= 1'b0;
      end else if (finish) begin
        complete_q <= 1'b1;
      end
      if (wr_index && complete_q) begin
        index_q <= wdata_in[2:0];
      end
      if (wr_mask) begin
        irq_mask_q <= wdata_in[flash_regs_pkg::IRQ_W-1:0];
      end
    end
  end
  // Protection loads from the configuration byte while the reset sequence runs
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || cfg_load_in) begin
      prot_q <= cfg_double_fault_in ? flash_regs_pkg::PROT_FULL
        : cfg_prot_byte_in;
    end else if (prot_accept) begin
      prot_q <= {wdata_in[7], 2'b00, wdata_in[4:0]};
    end
  end
  // Error flags: set wins over a clear in the same cycle
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      access_error_flag_q <= 1'b0;
      pviol_q <= 1'b0;
    end else begin
      access_error_flag_q <= (wr_status && wdata_in[flash_regs_pkg::BIT_COMPLETE] && !complete_q)
        || (access_error_flag_q && !clr_access_error_flag);
      pviol_q <= (finish && violate) || (pviol_q && !clr_pviol);
    end
  end
  // ****************************************
  // Command object array
  // ****************************************
  for (genvar i = 0; i < flash_regs_pkg::COB_WORDS; i++) begin : g_cob
    wire sel = index_q == 3'(i);
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        cob_q[i] <= 16'h0000;
      end else if (finish && !violate && cmd_code == flash_regs_pkg::CMD_READ_PROT
          && i == 2) begin
        cob_q[i] <= {8'h00, prot_q};
      end else if (sel && cob_wr_ok && wr_hi) begin
        cob_q[i][15:8] <= wdata_in;
      end else if (sel && cob_wr_ok && wr_lo) begin
        cob_q[i][7:0] <= wdata_in;
      end
    end
    AST_COB_FROZEN: assert property (@(posedge ref_clk_in) disable iff (rst_in)
      !complete_q && !finish |=> $stable(cob_q[i]))
      else $error("command word changed while busy");
  end
  // ****************************************
  // Read path and interrupts
  // ****************************************
  wire [15:0] cob_word = idx_ok ? cob_q[index_q] : 16'h0000;
  wire [7:0] status_val = {complete_q, 1'b0, access_error_flag_q, pviol_q, 4'h0};
  logic [7:0] rd_mux;
  always_comb begin
    case (addr_in)
      flash_regs_pkg::OFF_STATUS: rd_mux = status_val;
      flash_regs_pkg::OFF_DF_PROT: rd_mux = prot_q;
      flash_regs_pkg::OFF_CMD_INDEX: rd_mux = {5'h00, index_q};
      flash_regs_pkg::OFF_IRQ_MASK: rd_mux = {6'h00, irq_mask_q};
      flash_regs_pkg::OFF_IRQ_STAT: rd_mux = {6'h00, irq_stat_q};
      flash_regs_pkg::OFF_COB_HI: rd_mux = complete_q ? cob_word[15:8] : 8'h00;
      flash_regs_pkg::OFF_COB_LO: rd_mux = complete_q ? cob_word[7:0] : 8'h00;
      flash_regs_pkg::OFF_RSV_TEST: rd_mux = 8'h00;
      default: rd_mux = 8'h00;
    endcase
  end
  wire [flash_regs_pkg::IRQ_W-1:0] irq_ev = {finish && violate, finish};
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      irq_stat_q <= '0;
      rdata_q <= 8'h00;
      irq_q <= 1'b0;
      busy_out <= 1'b0;
      prot_out <= 8'h00;
    end else begin
      // A read clears, but a same-cycle event still lands
      irq_stat_q <= irq_ev | (rd_irq ? '0 : irq_stat_q);
      rdata_q <= rd_in ? rd_mux : 8'h00;
      irq_q <= |(irq_stat_q & irq_mask_q);
      busy_out <= state_d == ST_RUN;
      prot_out <= prot_q;
    end
  end
  assign rdata_out = rdata_q;
  assign irq_out = irq_q;
  // Word watched by the lock check; the result word is the one that moves most
  localparam int IDXW = 2;
  // ****************************************
  // Assertions
  // ****************************************
  AST_PROT_NO_WEAKEN: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !$past(cfg_load_in) && !prot_dis && $past(!prot_dis) |-> cur_size >= $past(cur_size))
    else $error("protection size shrank");
  AST_DISABLE_ONEWAY: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !cfg_load_in && !prot_dis |=> !prot_dis || $past(cfg_load_in))
    else $error("disable bit rose");
  AST_FULL_ON_FAULT: assert property (@(posedge ref_clk_in)
    cfg_load_in && cfg_double_fault_in |=> prot_q == flash_regs_pkg::PROT_FULL)
    else $error("double fault did not protect all");
  AST_LAUNCH_CLEARS: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    launch |=> !complete_q ##0 busy_out)
    else $error("launch did not clear complete");
  AST_LOCK: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !complete_q && !finish |=> cob_q[IDXW] == $past(cob_q[IDXW]))
    else $error("parameter changed while busy");
  AST_RUN_LEN: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    launch |=> !complete_q [*3] ##[1:300] complete_q)
    else $error("command did not complete");
  AST_VIOL: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    finish && violate |=> pviol_q)
    else $error("violation flag not set");
  AST_BLOCK_ERASE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    finish && blk_erase && !prot_dis |=> pviol_q)
    else $error("block erase allowed while protected");
  AST_UNUSED_IDX: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    rd_in && !idx_ok && (addr_in == flash_regs_pkg::OFF_COB_LO) |=> rdata_out == 8'h00)
    else $error("unused index read nonzero");
  AST_RSV: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    rd_in && addr_in == flash_regs_pkg::OFF_RSV_TEST |=> rdata_out == 8'h00)
    else $error("reserved register read nonzero");
  AST_RDATA_IDLE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !rd_in
    |=> rdata_out == 8'h00)
    else $error("read data not zero without read");
  AST_PROT_READBACK: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    rd_in && addr_in == flash_regs_pkg::OFF_DF_PROT
    |=> rdata_out == $past(prot_q))
    else $error("protection read back wrong");
  AST_PROT_OUT_COPY: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !rst_in
    |=> prot_out == $past(prot_q))
    else $error("protection output not a copy");
  AST_BUSY_FLAG: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    1'b1
    |-> busy_out == !complete_q)
    else $error("busy and complete disagree");
  AST_STATE_ONEHOT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    1'b1
    |-> $onehot(state_q))
    else $error("state not one-hot");
  AST_INDEX_FROZEN: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !complete_q
    |=> $stable(index_q))
    else $error("index changed while busy");
  AST_UNUSED_HI: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    rd_in && !idx_ok && addr_in == flash_regs_pkg::OFF_COB_HI
    |=> rdata_out == 8'h00)
    else $error("unused index high byte nonzero");
  AST_BUSY_READ_ZERO: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    rd_in && !complete_q && (wr_hi || wr_lo || addr_in == flash_regs_pkg::OFF_COB_LO)
    |=> rdata_out == 8'h00)
    else $error("command object readable while busy");
  AST_ACCESS_ERROR_FLAG_SET: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wr_status && wdata_in[flash_regs_pkg::BIT_COMPLETE] && !complete_q
    |=> access_error_flag_q)
    else $error("launch while busy did not flag");
  AST_PVIOL_HOLD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    pviol_q && !clr_pviol
    |=> pviol_q)
    else $error("violation flag lost");
  AST_NO_VIOL_CLEAN: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    finish && !violate && !pviol_q
    |=> !pviol_q)
    else $error("violation flag set without cause");
  AST_OPEN_DISABLED: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    finish && prot_dis && !pviol_q
    |=> !pviol_q)
    else $error("violation while protection disabled");
  AST_RANGE_EDGE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    finish && is_alter && !prot_dis && gaddr == prot_end
    |=> pviol_q)
    else $error("last protected byte not guarded");
  AST_BELOW_BASE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    finish && is_alter && gaddr < flash_regs_pkg::DF_BASE && !pviol_q
    |=> !pviol_q)
    else $error("address below base flagged");
  AST_RESET_LOAD: assert property (@(posedge ref_clk_in)
    rst_in
    |=> prot_q == ($past(cfg_double_fault_in) ? flash_regs_pkg::PROT_FULL : $past(cfg_prot_byte_in)))
    else $error("protection not loaded at reset");
  AST_WEAKEN_DISCARD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wr_prot && !cfg_load_in && !(dis_ok && size_ok)
    |=> $stable(prot_q))
    else $error("weakening write changed protection");
  AST_STRENGTHEN: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    prot_accept && !cfg_load_in
    |=> prot_q == {$past(wdata_in[7]), 2'b00, $past(wdata_in[4:0])})
    else $error("strengthening write not taken");
  AST_IRQ_LEVEL: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    !rst_in
    |=> irq_out == $past(|(irq_stat_q & irq_mask_q)))
    else $error("interrupt level wrong");
  AST_IRQ_DONE_SET: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    finish
    |=> irq_stat_q[flash_regs_pkg::IRQ_DONE])
    else $error("done status not set");
  AST_READPROT_RESULT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    finish && !violate && cmd_code == flash_regs_pkg::CMD_READ_PROT
    |=> cob_q[2] == {8'h00, $past(prot_q)})
    else $error("result word not written");
  AST_COUNT_IDLE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    state_q == ST_IDLE
    |-> count_q == 8'h00)
    else $error("cycle count running while idle");
  AST_COMPLETE_HOLD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    complete_q && !launch
    |=> complete_q)
    else $error("complete dropped without launch");
  AST_LAUNCH_GUARD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wr_status && wdata_in[flash_regs_pkg::BIT_COMPLETE] && complete_q && (access_error_flag_q || pviol_q)
    |=> complete_q)
    else $error("launch taken with an error flag set");
  AST_BLOCK_OPEN: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    finish && blk_erase && prot_dis && !pviol_q
    |=> !pviol_q)
    else $error("open block erase refused");
  AST_INDEX_WRITE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    wr_index && complete_q
    |=> index_q == $past(wdata_in[2:0]))
    else $error("index write lost");
  AST_COB_HI_READ: assert property (@(posedge ref_clk_in) disable iff (rst_in)
    rd_in && complete_q && idx_ok && addr_in == flash_regs_pkg::OFF_COB_HI
    |=> rdata_out == $past(cob_word[15:8]))
    else $error("high byte read wrong");
  COV_READ_PROT: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    finish && cmd_code == flash_regs_pkg::CMD_READ_PROT);
  COV_LAUNCH: cover property (@(posedge ref_clk_in) disable iff (rst_in) launch ##[1:20] finish);
  COV_VIOL: cover property (@(posedge ref_clk_in) disable iff (rst_in) finish && violate);
  COV_STRENGTHEN: cover property (@(posedge ref_clk_in) disable iff (rst_in) prot_accept);
  COV_REFUSE: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    wr_prot && !prot_accept);
endmodule : flash_protect_command_regs

// ===== verification/tb_top.sv
// Purpose: Self-checking bench for the flash protection and command register front end
// Assumes: Offsets, bit positions and command codes as the package declares them
// Notes: Engine busy time set through CMD_CYCLES to the package default of 8; irq check expects a mask bit of one to enable
`timescale 1ns/1ps
module tb_top;
  localparam int CYC = 8;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [4:0] addr_in = 5'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [7:0] cfg_prot_byte_in = 8'h83;
  logic cfg_double_fault_in = 1'b0;
  logic cfg_load_in = 1'b0;
  logic [7:0] rdata_out;
  logic irq_out;
  logic busy_out;
  logic [7:0] prot_out;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  flash_protect_command_regs #(.CMD_CYCLES(CYC)) flash_protect_command_regs_i (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .cfg_prot_byte_in(cfg_prot_byte_in),
    .cfg_double_fault_in(cfg_double_fault_in), .cfg_load_in(cfg_load_in),
    .rdata_out(rdata_out), .irq_out(irq_out), .busy_out(busy_out), .prot_out(prot_out));
  // ****************************************
  // Clock, timeout and report
  // ****************************************
  initial begin
    forever #2 ref_clk_in = ~ref_clk_in;
  end
  task automatic end_of_test();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // A hang in a bounded wait still ends in the one report
  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures = failures + 1;
      end_of_test();
    end
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  // ****************************************
  // Bus tasks
  // ****************************************
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 v = rdata_out;
  endtask : rd
  task automatic cob(input logic [2:0] i, input logic [7:0] h, input logic [7:0] l);
    wr(flash_regs_pkg::OFF_CMD_INDEX, {5'h00, i});
    wr(flash_regs_pkg::OFF_COB_HI, h);
    wr(flash_regs_pkg::OFF_COB_LO, l);
  endtask : cob
  task automatic do_reset(input logic [7:0] cfg);
    @(posedge ref_clk_in);
    cfg_prot_byte_in <= cfg;
    rst_in <= 1'b1;
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
  endtask : do_reset
  // ****************************************
  // Scenarios
  // ****************************************
  // Launch a command; optionally poke the locked object while it runs
  task automatic launch(input logic [7:0] cmd, input logic [22:0] ad, input logic viol,
                        input logic lock);
    logic [7:0] v;
    cob(3'h0, cmd, {1'b0, ad[22:16]});
    cob(3'h1, ad[15:8], ad[7:0]);
    wr(flash_regs_pkg::OFF_STATUS, 8'h80);
    for (int k = 0; k < 4 && busy_out !== 1'b1; k++) begin
      @(posedge ref_clk_in);
      #1;
    end
    chk("busy_rise", busy_out, 1'b1);
    if (lock) begin
      wr(flash_regs_pkg::OFF_COB_HI, 8'hEE);
      rd(flash_regs_pkg::OFF_COB_LO, v);
      chk("cob_busy_read", v, 8'h00);
    end
    for (int k = 0; k < CYC + 6 && busy_out !== 1'b0; k++) begin
      @(posedge ref_clk_in);
      #1;
    end
    chk("busy_fall", busy_out, 1'b0);
    rd(flash_regs_pkg::OFF_STATUS, v);
    chk("complete", v[flash_regs_pkg::BIT_COMPLETE], 1'b1);
    chk("violation", v[flash_regs_pkg::BIT_PVIOL], viol);
    if (lock) begin
      rd(flash_regs_pkg::OFF_COB_HI, v);
      chk("cob_locked", v, ad[15:8]);
    end
    if (viol) wr(flash_regs_pkg::OFF_STATUS, 8'h10);
  endtask : launch
  task automatic t_prot_writes();
    logic [7:0] v;
    logic [7:0] wv [4] = '{8'h05, 8'h03, 8'h85, 8'h07};
    logic [7:0] ev [4] = '{8'h05, 8'h05, 8'h05, 8'h07};
    for (int i = 0; i < 4; i++) begin
      wr(flash_regs_pkg::OFF_DF_PROT, wv[i]);
      rd(flash_regs_pkg::OFF_DF_PROT, v);
      chk("prot_write", v, ev[i]);
    end
    chk("prot_out", prot_out, 8'h07);
  endtask : t_prot_writes
  task automatic t_cob_regs();
    logic [7:0] v;
    cob(3'h2, 8'hAB, 8'hCD);
    rd(flash_regs_pkg::OFF_COB_HI, v);
    chk("cob_hi", v, 8'hAB);
    rd(flash_regs_pkg::OFF_COB_LO, v);
    chk("cob_lo", v, 8'hCD);
    cob(3'h6, 8'h5A, 8'hA5);
    rd(flash_regs_pkg::OFF_COB_HI, v);
    chk("cob_unimpl_hi", v, 8'h00);
    wr(flash_regs_pkg::OFF_RSV_TEST, 8'hFF);
    rd(flash_regs_pkg::OFF_RSV_TEST, v);
    chk("reserved", v, 8'h00);
  endtask : t_cob_regs
  task automatic t_irq();
    logic [7:0] v;
    logic a;
    rd(flash_regs_pkg::OFF_IRQ_STAT, v);
    launch(flash_regs_pkg::CMD_PROGRAM, 23'h10_1000, 1'b0, 1'b0);
    wr(flash_regs_pkg::OFF_IRQ_MASK, 8'h00);
    repeat (2) @(posedge ref_clk_in);
    #1 a = irq_out;
    chk("irq_masked", a, 1'b0);
    wr(flash_regs_pkg::OFF_IRQ_MASK, 8'h03);
    repeat (2) @(posedge ref_clk_in);
    #1;
    chk("irq_unmasked", irq_out, 1'b1);
    rd(flash_regs_pkg::OFF_IRQ_STAT, v);
    chk("irq_done", v[flash_regs_pkg::IRQ_DONE], 1'b1);
    repeat (2) @(posedge ref_clk_in);
    #1;
    chk("irq_cleared", irq_out, 1'b0);
  endtask : t_irq
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0] v;
    do_reset(8'h83);
    rd(flash_regs_pkg::OFF_DF_PROT, v);
    chk("prot_reset", v, 8'h83);
    t_cob_regs();
    launch(flash_regs_pkg::CMD_PROGRAM, 23'h10_0000, 1'b0, 1'b0);
    t_prot_writes();
    launch(flash_regs_pkg::CMD_PROGRAM, 23'h10_0100, 1'b1, 1'b1);
    launch(flash_regs_pkg::CMD_PROGRAM, 23'h10_07FE, 1'b1, 1'b0);
    launch(flash_regs_pkg::CMD_PROGRAM, 23'h10_0800, 1'b0, 1'b0);
    launch(flash_regs_pkg::CMD_READ_PROT, 23'h00_0000, 1'b0, 1'b0);
    wr(flash_regs_pkg::OFF_CMD_INDEX, 8'h02);
    rd(flash_regs_pkg::OFF_COB_LO, v);
    chk("read_prot_result", v, 8'h07);
    launch(flash_regs_pkg::CMD_ERASE_BLOCK, 23'h10_0000, 1'b1, 1'b0);
    t_irq();
    cfg_double_fault_in <= 1'b1;
    cfg_load_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    cfg_load_in <= 1'b0;
    cfg_double_fault_in <= 1'b0;
    rd(flash_regs_pkg::OFF_DF_PROT, v);
    chk("prot_double_fault", v, flash_regs_pkg::PROT_FULL);
    do_reset(8'h80);
    rd(flash_regs_pkg::OFF_DF_PROT, v);
    chk("prot_second_reset", v, 8'h80);
    end_of_test();
  end
endmodule : tb_top
